//--- core/eleven_source_interrupt_unit.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "irq_unit_defs.svh"
module eleven_source_interrupt_unit
(
   // Clock and reset
   input  wire logic                      I_CORE_CLK,
   input  wire logic                      I_RST_N,
   // Wishbone slave
   input  wire logic                      I_WB_CYC,
   input  wire logic                      I_WB_STB,
   input  wire logic                      I_WB_WE,
   input  wire logic [7:0]                I_WB_ADR,
   input  wire logic [3:0]                I_WB_SEL,
   input  wire logic [31:0]               I_WB_DAT,
   output logic      [31:0]               O_WB_DAT,
   output logic                           O_WB_ACK,
   // Sources
   input  wire logic                      I_EXT0,
   input  wire logic                      I_TIMER0,
   input  wire logic                      I_EXT1,
   input  wire logic                      I_TIMER1,
   input  wire logic                      I_SERIAL,
   input  wire irq_unit_pkg::link_flags_t I_LINK,
   input  wire logic [7:0]                I_XFER0_CONTROL,
   input  wire logic [7:0]                I_XFER1_CONTROL,
   // Core handshake
   input  wire logic                      I_VEC_TAKEN,
   input  wire logic                      I_RETI,
   output logic                           O_IRQ_REQ,
   output logic      [7:0]                O_IRQ_VECTOR
);
   logic [7:0]             base_en_q;
   logic [7:0]             base_pri_q;
   logic [7:0]             en_hi_q;
   logic [7:0]             pri_hi_q;
   logic                   ack_q;
   logic [31:0]            rdat_q;
   logic                   in_hi_q;
   logic                   in_lo_q;
   logic                   req_q;
   logic [7:0]             vec_q;
   logic                   req_hi_q;
   irq_unit_pkg::src_vec_t raw;
   irq_unit_pkg::src_vec_t en;
   irq_unit_pkg::src_vec_t pri;
   irq_unit_pkg::src_vec_t pend;
   logic                   win_any;
   logic                   win_hi;
   logic [7:0]             win_vec;
   logic                   wr_stb;

   // Vector for a poll position
   function automatic logic [7:0] vec_of(input int idx);
      unique case (idx)
         0:       vec_of = `VEC_EXT0;
         1:       vec_of = `VEC_RXOK;
         2:       vec_of = `VEC_TMR0;
         3:       vec_of = `VEC_RXERR;
         4:       vec_of = `VEC_X0;
         5:       vec_of = `VEC_EXT1;
         6:       vec_of = `VEC_TXOK;
         7:       vec_of = `VEC_X1;
         8:       vec_of = `VEC_TMR1;
         9:       vec_of = `VEC_TXERR;
         default: vec_of = `VEC_SER;
      endcase
   endfunction

   // Byte-lane write with a mask of implemented bits
   function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] mask);
      wr8 = I_WB_SEL[0] ? (I_WB_DAT[7:0] & mask) : old;
   endfunction

   // Source requests; flags are level-held by their owners, never cleared here
   always_comb
   begin
      raw[0]  = I_EXT0;
      raw[1]  = I_LINK.dma_mode ? I_LINK.rx_done_flag : I_LINK.rx_fifo_not_empty;
      raw[2]  = I_TIMER0;
      raw[3]  = I_LINK.rx_checksum_error | I_LINK.rx_overflow
              | I_LINK.rx_aborted | I_LINK.rx_alignment_fault;
      raw[4]  = I_XFER0_CONTROL[`DONE_BIT];
      raw[5]  = I_EXT1;
      raw[6]  = I_LINK.dma_mode ? I_LINK.tx_done_flag : I_LINK.tx_fifo_not_full;
      raw[7]  = I_XFER1_CONTROL[`DONE_BIT];
      raw[8]  = I_TIMER1;
      raw[9]  = I_LINK.missing_acknowledge | I_LINK.tx_collision_detect
              | (I_LINK.dma_mode & I_LINK.tx_underflow);
      raw[10] = I_SERIAL;
   end

   // Map register bits onto poll positions
   always_comb
   begin
      en  = {base_en_q[4], en_hi_q[5], base_en_q[3], en_hi_q[4], en_hi_q[3], base_en_q[2],
             en_hi_q[2], en_hi_q[1], base_en_q[1], en_hi_q[0], base_en_q[0]};
      pri = {base_pri_q[4], pri_hi_q[5], base_pri_q[3], pri_hi_q[4], pri_hi_q[3],
             base_pri_q[2], pri_hi_q[2], pri_hi_q[1], base_pri_q[1], pri_hi_q[0],
             base_pri_q[0]};
      pend = raw & en & {`NSRC{base_en_q[`GLOBAL_EN_BIT]}};
   end

   // Two-level fixed poll: high level first, then index order
   always_comb
   begin
      win_any = 1'b0;
      win_hi  = 1'b0;
      win_vec = 8'h00;
      for (int i = `NSRC - 1; i >= 0; i--)
      begin
         if (pend[i] && pri[i])
         begin
            win_any = 1'b1;
            win_hi  = 1'b1;
            win_vec = vec_of(i);
         end
      end
      if (!win_hi)
      begin
         for (int i = `NSRC - 1; i >= 0; i--)
         begin
            if (pend[i])
            begin
               win_any = 1'b1;
               win_vec = vec_of(i);
            end
         end
      end
   end

   assign wr_stb = I_WB_CYC && I_WB_STB && I_WB_WE && !ack_q;

   // Register writes; only the low byte lane carries data
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         base_en_q  <= 8'h00;
         base_pri_q <= 8'h00;
         en_hi_q    <= 8'h00;
         pri_hi_q   <= 8'h00;
      end
      else if (wr_stb)
      begin
         unique case (I_WB_ADR)
            `ADDR_BASE_EN:  base_en_q  <= wr8(base_en_q, `BASE_EN_MASK);
            `ADDR_BASE_PRI: base_pri_q <= wr8(base_pri_q, `LOW5_MASK);
            `ADDR_EN_HI:    en_hi_q    <= wr8(en_hi_q, `HI6_MASK);
            `ADDR_PRI_HI:   pri_hi_q   <= wr8(pri_hi_q, `HI6_MASK);
            default:        ;
         endcase
      end
   end

   // Bus answer one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= I_WB_CYC && I_WB_STB && !ack_q;
         unique case (I_WB_ADR)
            `ADDR_BASE_EN:  rdat_q <= {24'h00_0000, base_en_q};
            `ADDR_BASE_PRI: rdat_q <= {24'h00_0000, base_pri_q};
            `ADDR_EN_HI:    rdat_q <= {24'h00_0000, en_hi_q};
            `ADDR_PRI_HI:   rdat_q <= {24'h00_0000, pri_hi_q};
            `ADDR_SERVICE:  rdat_q <= {30'h0000_0000, in_hi_q, in_lo_q};
            `ADDR_STATUS:   rdat_q <= {21'h00_0000, pend};
            default:        rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   // Request to the core, gated by the level now in service
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         req_q    <= 1'b0;
         vec_q    <= 8'h00;
         req_hi_q <= 1'b0;
      end
      else
      begin
         req_q    <= win_any && !in_hi_q && !(in_lo_q && !win_hi) && !I_VEC_TAKEN;
         vec_q    <= win_vec;
         req_hi_q <= win_hi;
      end
   end

   // Service levels: taken sets the level, return unwinds the newest one
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         in_hi_q <= 1'b0;
         in_lo_q <= 1'b0;
      end
      else if (I_VEC_TAKEN && req_q)
      begin
         if (req_hi_q)
            in_hi_q <= 1'b1;
         else
            in_lo_q <= 1'b1;
      end
      else if (I_RETI)
      begin
         if (in_hi_q)
            in_hi_q <= 1'b0;
         else
            in_lo_q <= 1'b0;
      end
   end

   assign O_WB_ACK     = ack_q;
   assign O_WB_DAT     = rdat_q;
   assign O_IRQ_REQ    = req_q;
   assign O_IRQ_VECTOR = vec_q;
endmodule

//--- core/irq_unit_defs.svh
// Functional notes
// - Eleven sources: five original plus six added, each maskable and prioritised.
// - Added enables at offset c8; bits 7 and 6 reserved, read zero.
// - Added priority levels at offset f8, one bit per added source.
// - Tx error vectors to 04b: no-ack or collision, plus underflow under DMA.
// - Transfer channel 1 done vectors to 053 when enabled.
// - Tx ok vectors to 043: fifo not full under CPU, tx done under DMA.
// - Transfer channel 0 done vectors to 03b when enabled.
// - Rx error vectors to 033 on checksum, overflow, abort or alignment fault.
// - Rx ok vectors to 02b: fifo not empty under CPU, rx done under DMA.
// - Priority bit one beats priority bit zero; same scheme for both registers.
// - Priority bits: 5 tx err, 4 xfer1, 3 tx ok, 2 xfer0, 1 rx err, 0 rx ok.
// - Equal level poll order: ext0,rxok,tmr0,rxerr,x0,ext1,txok,x1,tmr1,txerr,serial.
// - Original sources keep base bits 0-4 and vectors 03,0b,13,1b,23.
`ifndef IRQ_UNIT_DEFS_SVH
`define IRQ_UNIT_DEFS_SVH
`define ADDR_BASE_EN     8'ha8
`define ADDR_BASE_PRI    8'hb8
`define ADDR_EN_HI       8'hc8
`define ADDR_PRI_HI      8'hf8
`define ADDR_SERVICE     8'h00
`define ADDR_STATUS      8'h04
`define BASE_EN_MASK     8'h9f
`define LOW5_MASK        8'h1f
`define HI6_MASK         8'h3f
`define GLOBAL_EN_BIT    7
`define NSRC             11
`define VEC_EXT0         8'h03
`define VEC_TMR0         8'h0b
`define VEC_EXT1         8'h13
`define VEC_TMR1         8'h1b
`define VEC_SER          8'h23
`define VEC_RXOK         8'h2b
`define VEC_RXERR        8'h33
`define VEC_X0           8'h3b
`define VEC_TXOK         8'h43
`define VEC_TXERR        8'h4b
`define VEC_X1           8'h53
`define DONE_BIT         1
`endif

//--- core/irq_unit_pkg.sv
package irq_unit_pkg;
   // Link status flags from the serial link channel
   typedef struct packed {
      logic dma_mode;
      logic missing_acknowledge;
      logic tx_collision_detect;
      logic tx_underflow;
      logic tx_fifo_not_full;
      logic tx_done_flag;
      logic rx_checksum_error;
      logic rx_overflow;
      logic rx_aborted;
      logic rx_alignment_fault;
      logic rx_fifo_not_empty;
      logic rx_done_flag;
   } link_flags_t;
   // Requests in polling order, index 0 polled first
   typedef logic [10:0] src_vec_t;
endpackage

//--- verification/irq_unit_monitor.sv
`timescale 1ns/1ps
module irq_unit_monitor
(
   // Clock, reset and bus
   input wire logic        I_CORE_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [7:0]  I_WB_ADR,
   input wire logic [31:0] O_WB_DAT,
   input wire logic        O_WB_ACK,
   // Core handshake
   input wire logic        I_VEC_TAKEN,
   input wire logic        O_IRQ_REQ,
   input wire logic [7:0]  O_IRQ_VECTOR
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   // Named steps, each used by one property
   sequence grab;
      O_IRQ_REQ && I_VEC_TAKEN;
   endsequence
   sequence rd_hi;
      O_WB_ACK && !I_WB_WE && (I_WB_ADR inside {8'hc8, 8'hf8});
   endsequence
   ack_once_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
   ack_time_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("ack late");
   ack_cause_a: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB))
      else $error("ack without request");
   rd_zero_a: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0) else $error("high lanes");
   hi_rsvd_a: assert property (rd_hi |-> O_WB_DAT[7:6] == 2'h0)
      else $error("reserved bits set");
   unmapped_a: assert property (O_WB_ACK && !I_WB_WE
      && !(I_WB_ADR inside {8'h00, 8'h04, 8'ha8, 8'hb8, 8'hc8, 8'hf8}) |-> O_WB_DAT == 32'h0)
      else $error("unmapped read not zero");
   vec_legal_a: assert property (O_IRQ_REQ |-> O_IRQ_VECTOR inside {8'h03, 8'h0b, 8'h13,
      8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b, 8'h43, 8'h4b, 8'h53})
      else $error("bad vector");
   req_drop_a: assert property (grab |=> !O_IRQ_REQ)
      else $error("request held after take");
endmodule
bind eleven_source_interrupt_unit irq_unit_monitor i_irq_unit_monitor (.I_CORE_CLK, .I_RST_N,
   .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .O_WB_DAT, .O_WB_ACK, .I_VEC_TAKEN, .O_IRQ_REQ,
   .O_IRQ_VECTOR);

//--- verification/core_model.sv
`timescale 1ns/1ps
module core_model
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Request side and control from the bench
   input  wire logic i_req,
   input  wire logic i_accept,
   input  wire logic i_ret,
   // Answers to the unit
   output logic      o_taken,
   output logic      o_reti
);
   // Take only a standing request; one pulse so a service is never marked twice
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_taken <= 1'b0;
         o_reti  <= 1'b0;
      end
      else
      begin
         o_taken <= i_req && i_accept && !o_taken;
         o_reti  <= i_ret && !o_reti;
      end
   end
endmodule

//--- verification/eleven_source_interrupt_unit_test.sv
`timescale 1ns/1ps
module eleven_source_interrupt_unit_test;
   logic        clk, rst_n, cyc, stb, we, accept, ret, dma, ack, req, taken, reti;
   logic [7:0]  adr, vec;
   logic [31:0] wdat, rdat, q;
   logic [10:0] s;
   logic [2:0]  x;
   int          failures, checks, cycles;
   logic [7:0]  vt [11] = '{8'h03, 8'h2b, 8'h0b, 8'h33, 8'h3b, 8'h13, 8'h43, 8'h53, 8'h1b,
                             8'h4b, 8'h23};
   logic [7:0]  dv [3] = '{8'h2b, 8'h43, 8'h4b};
   irq_unit_pkg::link_flags_t link;
   // Flags stay up until the bench lowers them, as the link blocks do
   assign link = {dma, s[9], 1'b0, x[2], s[6], x[1], s[3], 3'h0, s[1], x[0]};
   eleven_source_interrupt_unit i_eleven_source_interrupt_unit (.I_CORE_CLK(clk),
      .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
      .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EXT0(s[0]),
      .I_TIMER0(s[2]), .I_EXT1(s[5]), .I_TIMER1(s[8]), .I_SERIAL(s[10]), .I_LINK(link),
      .I_XFER0_CONTROL({6'h0, s[4], 1'b0}), .I_XFER1_CONTROL({6'h0, s[7], 1'b0}),
      .I_VEC_TAKEN(taken), .I_RETI(reti), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec));
   core_model i_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_accept(accept),
      .i_ret(ret), .o_taken(taken), .o_reti(reti));
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         end_sim;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      // A bus that never answers is a mismatch, not a silent pass
      if (ack !== 1'b1)
      begin
         failures++;
         $display("[FAIL] %0t no bus answer", $time);
      end
      q = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask
   // Settle a source change, then look at request and vector together
   task automatic see(input logic r, input logic [7:0] v);
      repeat (3) @(posedge clk);
      chk({23'h0, req, vec}, {23'h0, r, r ? v : vec});
   endtask
   task automatic take();
      accept <= 1'b1;
      @(posedge clk);
      accept <= 1'b0;
   endtask
   task automatic t_regs();
      wb(0, 8'hc8, 8'h0);
      chk(q, 32'h0);
      wb(1, 8'hc8, 8'hff);
      wb(0, 8'hc8, 8'h0);
      chk(q, 32'h3f);
      wb(1, 8'hf8, 8'hff);
      wb(0, 8'hf8, 8'h0);
      chk(q, 32'h3f);
      wb(1, 8'hf8, 8'h0);
      wb(0, 8'h10, 8'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_order();
      wb(1, 8'ha8, 8'h9f);
      for (int i = 0; i < 11; i++)
      begin
         s <= 11'h7ff << i;
         see(1'b1, vt[i]);
      end
      wb(1, 8'hc8, 8'h1f);
      s <= 11'h200;
      see(1'b0, 8'h0);
   endtask
   task automatic t_dma();
      wb(1, 8'hc8, 8'h3f);
      {s, dma} <= 12'h001;
      for (int j = 0; j < 3; j++)
      begin
         x <= 3'b001 << j;
         see(1'b1, dv[j]);
      end
      // Under DMA control fifo-not-full must not request; checksum error still does
      x <= 3'h0;
      s <= 11'h040;
      see(1'b0, 8'h0);
      s <= 11'h048;
      see(1'b1, 8'h33);
   endtask
   task automatic t_pri();
      {s, dma} <= 12'hffe;
      wb(1, 8'hf8, 8'h20);
      see(1'b1, 8'h4b);
      take();
      see(1'b0, 8'h0);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      see(1'b1, 8'h4b);
      wb(1, 8'hf8, 8'h0);
      take();
      see(1'b0, 8'h0);
      wb(1, 8'hf8, 8'h20);
      see(1'b1, 8'h4b);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      {rst_n, cyc, stb, we, accept, ret, dma, adr, wdat, s, x} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_order();
      t_dma();
      t_pri();
      end_sim();
   end
endmodule
